// ---- bench/csgh_properties.sv ----
// checker for the register bus handshake, status pin and carrier sense timing
`timescale 1ns/1ps
module csgh_props (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // register bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // receiver side
    input wire carrier_sense,
    input wire status_pin,
    input wire status_sel_cs,
    input wire second_amp_floor,
    input wire avg_valid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence b_in_time;
        ##[1:2] s_axi_bvalid;
    endsequence
    a_write_answer: assert property (aw_w_taken |-> b_in_time)
        else $error("write response missing");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_busy_readies: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_status_follows: assert property (
        status_sel_cs && $past(status_sel_cs) |-> status_pin == $past(carrier_sense))
        else $error("status pin does not follow carrier sense");
    a_floor_on_write: assert property (
        $changed(second_amp_floor) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("amp floor changed without a write");
    a_cs_after_avg: assert property (
        $changed(carrier_sense) |-> avg_valid || $past(avg_valid) || $past(avg_valid, 2))
        else $error("carrier sense changed without a new average");
endmodule

bind csgh_top csgh_props u_props (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .carrier_sense(carrier_sense), .status_pin(status_pin),
    .status_sel_cs(status_sel_cs), .second_amp_floor(second_amp_floor),
    .avg_valid(avg_valid));

// ---- bench/test_carrier_sense_gain_hold.sv ----
// self-checking bench: registers, averaging, carrier sense runs and level holds
`timescale 1ns/1ps
`include "csgh_defs.vh"
module test_carrier_sense_gain_hold;
    reg         aclk = 1'b0;
    reg         aresetn = 1'b0;
    reg         awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    reg  [7:0]  awa = 8'h00, ara = 8'h00, mag = 8'h00, last_avg = 8'h00;
    reg  [31:0] wd = 32'h0, got;
    reg         ft = 1'b0, at = 1'b0, tk = 1'b0, mv = 1'b0, gc = 1'b0;
    reg         chs = 1'b0, pu = 1'b0, lock = 1'b1, sel = 1'b1;
    wire        awr, wr, bv, arr, rv, cs, sp, frz, flo, avv;
    wire [1:0]  br, rr;
    wire [31:0] rd;
    wire [7:0]  avm;
    integer     num_errors = 0, compares = 0, i, k, n;

    csgh_top DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .filt_tick(ft), .adc_tick(at), .mag_valid(mv), .mag_in(mag),
        .cs_threshold(8'h80), .gain_change(gc), .chan_switch(chs), .rx_powerup(pu),
        .synth_lock_pin(lock), .status_sel_cs(sel), .status_pin(sp),
        .carrier_sense(cs), .levels_frozen(frz), .second_amp_floor(flo),
        .avg_valid(avv), .avg_mag(avm));

    always #2.5 aclk = ~aclk;
    // filter clock at half rate so holds in filter clocks and converter clocks differ
    always @(posedge aclk) begin
        tk <= ~tk;
        ft <= tk;
        at <= 1'b1;
        if (avv === 1'b1)
            last_avg <= avm;
    end

    task close_out;
        begin
            $display("compares %0d num_errors %0d", compares, num_errors);
            if (num_errors == 0 && compares > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    task check(input string nm, input [31:0] e, input [31:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("mismatch %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    task fail_wait;
        begin
            num_errors = num_errors + 1;
            $display("mismatch bus_answer expected response seen none");
            close_out;
        end
    endtask

    task axi_write(input [7:0] a, input [31:0] d, input [1:0] e);
        integer t;
        begin
            @(posedge aclk);
            awv <= 1'b1;
            awa <= a;
            wv <= 1'b1;
            wd <= d;
            bry <= 1'b1;
            for (t = 0; t < 50; t = t + 1) begin
                @(posedge aclk);
                if (awr === 1'b1)
                    awv <= 1'b0;
                if (wr === 1'b1)
                    wv <= 1'b0;
                if (bv === 1'b1) begin
                    check("bresp", e, br);
                    t = 99;
                end
            end
            if (t != 100)
                fail_wait;
            bry <= 1'b0;
        end
    endtask

    task axi_read(input [7:0] a, input [1:0] e, output [31:0] d);
        integer t;
        begin
            @(posedge aclk);
            arv <= 1'b1;
            ara <= a;
            rry <= 1'b1;
            for (t = 0; t < 50; t = t + 1) begin
                @(posedge aclk);
                if (arr === 1'b1)
                    arv <= 1'b0;
                if (rv === 1'b1) begin
                    d = rd;
                    check("rresp", e, rr);
                    t = 99;
                end
            end
            if (t != 100)
                fail_wait;
            rry <= 1'b0;
        end
    endtask

    task feed(input [7:0] v, input [7:0] step, input integer cnt);
        integer j;
        begin
            for (j = 0; j < cnt; j = j + 1) begin
                @(posedge aclk);
                mv <= 1'b1;
                mag <= v + step * j[7:0];
                @(posedge aclk);
                mv <= 1'b0;
            end
            repeat (4) @(posedge aclk);
        end
    endtask

    task cs_step(input [7:0] v, input e);
        begin
            feed(v, 8'h00, 2);
            check("carrier_sense", {31'h0, e}, {31'h0, cs});
            check("status_pin", {31'h0, e}, {31'h0, sp});
        end
    endtask

    // src: 0 channel pin, 1 powerup pin, 2 lock loss, 3 event register, 4 none
    task hold_case(input [7:0] cfg, input integer src, input integer e);
        begin
            axi_write(`CSGH_ADDR_HOLD_CFG, {24'h0, cfg}, `CSGH_RESP_OKAY);
            @(posedge aclk);
            chs <= (src == 0);
            pu <= (src == 1);
            lock <= (src != 2);
            if (src == 3)
                axi_write(`CSGH_ADDR_EVENT, 32'h3, `CSGH_RESP_OKAY);
            @(posedge aclk);
            chs <= 1'b0;
            pu <= 1'b0;
            // lock loss is seen only after the pin synchroniser
            if (src == 2)
                repeat (4) @(posedge aclk);
            gc <= (src != 3);
            @(posedge aclk);
            gc <= 1'b0;
            lock <= 1'b1;
            n = 0;
            for (k = 0; k < 400; k = k + 1) begin
                @(posedge aclk);
                if (frz === 1'b1)
                    n = n + 1;
            end
            compares = compares + 1;
            if (n < e - 6 || n > e + 6) begin
                num_errors = num_errors + 1;
                $display("mismatch frozen_cycles expected %0d seen %0d", e, n);
            end
        end
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`CSGH_ADDR_HOLD_CFG, `CSGH_RESP_OKAY, got);
        check("hold_cfg", {24'h0, `CSGH_HOLD_RST}, got);
        axi_read(`CSGH_ADDR_GAIN_CFG, `CSGH_RESP_OKAY, got);
        check("gain_cfg", {24'h0, `CSGH_GAIN_RST}, got);
        axi_read(`CSGH_ADDR_STATUS, `CSGH_RESP_OKAY, got);
        check("status", 32'h4, got);
        axi_read(`CSGH_ADDR_EVENT, `CSGH_RESP_OKAY, got);
        check("event", 32'h0, got);
        axi_read(8'h00, `CSGH_RESP_SLVERR, got);
        check("unmapped", 32'h0, got);
        axi_write(8'h00, 32'hff, `CSGH_RESP_SLVERR);
        for (i = 0; i < 4; i = i + 1) begin
            axi_write(`CSGH_ADDR_GAIN_CFG, {24'h0, i[0], 5'h01, i[1:0]}, `CSGH_RESP_OKAY);
            @(posedge aclk);
            check("amp_floor", {31'h0, i[0]}, {31'h0, flo});
            axi_read(`CSGH_ADDR_GAIN_CFG, `CSGH_RESP_OKAY, got);
            check("gain_cfg", {24'h0, i[0], 5'h01, i[1:0]}, got);
            feed(8'h00, 8'h08, 2 << i);
            check("avg_mag", 4 * ((2 << i) - 1), {24'h0, last_avg});
        end
        axi_write(`CSGH_ADDR_GAIN_CFG, 32'h44, `CSGH_RESP_OKAY);
        for (i = 0; i < 4; i = i + 1) begin
            axi_write(`CSGH_ADDR_HOLD_CFG, {24'h0, i[1:0], 6'h05}, `CSGH_RESP_OKAY);
            cs_step(8'h10, 1'b0);
            for (k = 0; k < i; k = k + 1)
                cs_step(8'hc0, 1'b0);
            if (i > 0) begin
                cs_step(8'h10, 1'b0);
                for (k = 0; k < i; k = k + 1)
                    cs_step(8'hc0, 1'b0);
            end
            cs_step(8'hc0, 1'b1);
            cs_step(8'h10, 1'b0);
        end
        axi_write(`CSGH_ADDR_HOLD_CFG, 32'h25, `CSGH_RESP_OKAY);
        cs_step(8'hc0, 1'b1);
        cs_step(8'h10, 1'b1);
        cs_step(8'hc0, 1'b1);
        cs_step(8'h10, 1'b1);
        cs_step(8'h10, 1'b0);
        sel <= 1'b0;
        repeat (6) @(posedge aclk);
        check("status_lock", 32'h1, {31'h0, sp});
        sel <= 1'b1;
        hold_case(8'h38, 4, 0);
        hold_case(8'h38, 0, 96);
        hold_case(8'h23, 1, 128);
        hold_case(8'h29, 2, 48);
        hold_case(8'h34, 3, 80);
        axi_write(`CSGH_ADDR_HOLD_CFG, 32'h3c, `CSGH_RESP_OKAY);
        repeat (300) @(posedge aclk);
        check("frozen", 32'h1, {31'h0, frz});
        axi_read(`CSGH_ADDR_STATUS, `CSGH_RESP_OKAY, got);
        check("status", 32'h6, got);
        close_out;
    end
endmodule

// ---- core/csgh_defs.vh ----
// register map, field positions, reset values and timing counts for carrier sense gain hold
`ifndef CSGH_DEFS_VH
`define CSGH_DEFS_VH

// register byte offsets (index times four)
`define CSGH_IDX_HOLD_CFG     8'h11
`define CSGH_IDX_GAIN_CFG     8'h12
`define CSGH_IDX_STATUS       8'h13
`define CSGH_IDX_EVENT        8'h14
`define CSGH_ADDR_HOLD_CFG    8'h44
`define CSGH_ADDR_GAIN_CFG    8'h48
`define CSGH_ADDR_STATUS      8'h4c
`define CSGH_ADDR_EVENT       8'h50

// carrier_sense_hold_cfg fields
`define CSGH_SET_HI           7
`define CSGH_SET_LO           6
`define CSGH_CLR_BIT          5
`define CSGH_WAIT_HI          4
`define CSGH_WAIT_LO          2
`define CSGH_FRZ_HI           1
`define CSGH_FRZ_LO           0
`define CSGH_HOLD_RST         8'h65

// amp_gain_limit_cfg fields
`define CSGH_FLOOR_BIT        7
`define CSGH_AVG_HI           1
`define CSGH_AVG_LO           0
`define CSGH_GAIN_RST         8'h45

// event register bits (write one to raise a one-cycle event)
`define CSGH_EV_GAIN          0
`define CSGH_EV_CHAN          1
`define CSGH_EV_LOCK          2
`define CSGH_EV_PWRUP         3

// axi response codes
`define CSGH_RESP_OKAY        2'h0
`define CSGH_RESP_SLVERR      2'h2

// hold timing
`define CSGH_WAIT_INDEF       3'h7
`define CSGH_FRZ_BASE         8'h10

// gain-change hold lengths in filter clocks, codes 0 to 6
`define CSGH_WAIT_C0          6'h10
`define CSGH_WAIT_C1          6'h14
`define CSGH_WAIT_C2          6'h18
`define CSGH_WAIT_C3          6'h1c
`define CSGH_WAIT_C4          6'h20
`define CSGH_WAIT_C5          6'h28
`define CSGH_WAIT_C6          6'h30

// carrier sense run counter ceilings
`define CSGH_SET_RUN_MAX      3'h4
`define CSGH_CLR_RUN_MAX      2'h2

`endif

// ---- core/csgh_freeze_timer.v ----
// freeze timer: gain-change hold in filter clocks plus extra converter-clock hold
`timescale 1ns/1ps
`include "csgh_defs.vh"
module csgh_freeze_timer (
    // clock and reset
    input  wire       aclk,
    input  wire       aresetn,
    // timing strobes
    input  wire       filt_tick,
    input  wire       adc_tick,
    // configuration
    input  wire [2:0] wait_sel,
    input  wire [1:0] frz_sel,
    // events
    input  wire       gain_change,
    input  wire       retune_event,
    // result
    output reg        frozen
);
    reg [5:0] wait_cnt_r;
    reg [7:0] frz_cnt_r;
    reg       armed_r;

    function [5:0] wait_len;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    wait_len = `CSGH_WAIT_C0;
                3'h1:    wait_len = `CSGH_WAIT_C1;
                3'h2:    wait_len = `CSGH_WAIT_C2;
                3'h3:    wait_len = `CSGH_WAIT_C3;
                3'h4:    wait_len = `CSGH_WAIT_C4;
                3'h5:    wait_len = `CSGH_WAIT_C5;
                default: wait_len = `CSGH_WAIT_C6;
            endcase
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            wait_cnt_r <= 6'h0;
            frz_cnt_r  <= 8'h0;
            armed_r    <= 1'b0;
            frozen     <= 1'b0;
        end else begin
            // a retune arms the gain-change hold and starts the extra freeze
            if (retune_event) begin
                armed_r   <= 1'b1;
                frz_cnt_r <= `CSGH_FRZ_BASE << frz_sel;
            end else if (adc_tick && frz_cnt_r != 8'h0) begin
                frz_cnt_r <= frz_cnt_r - 8'h1;
            end
            if (gain_change && (armed_r || retune_event)) begin
                wait_cnt_r <= wait_len(wait_sel);
                armed_r    <= 1'b0;
            end else if (filt_tick && wait_cnt_r != 6'h0) begin
                wait_cnt_r <= wait_cnt_r - 6'h1;
            end
            frozen <= (wait_sel == `CSGH_WAIT_INDEF) || (wait_cnt_r != 6'h0)
                      || (frz_cnt_r != 8'h0) || retune_event;
        end
    end
endmodule

// ---- core/csgh_mag_avg.v ----
// block averager of filter output magnitudes over 2, 4, 8 or 16 samples
`timescale 1ns/1ps
module csgh_mag_avg #(
    parameter MAG_W = 8
) (
    // clock and reset
    input  wire             aclk,
    input  wire             aresetn,
    // control
    input  wire [1:0]       avg_sel,
    input  wire             freeze,
    // sample stream in
    input  wire             in_valid,
    input  wire [MAG_W-1:0] in_mag,
    // averaged sample out
    output reg              out_valid,
    output reg  [MAG_W-1:0] out_mag
);
    reg  [MAG_W+3:0] acc_r;
    reg  [3:0]       cnt_r;
    wire [3:0]       last_cnt = (4'h2 << avg_sel) - 4'h1;
    wire [MAG_W+3:0] sum     = acc_r + {4'h0, in_mag};
    // a block sum divided by the block length always fits the sample width
    wire [MAG_W+3:0] avg_full = sum >> ({2'h0, avg_sel} + 4'h1);

    always @(posedge aclk) begin
        if (!aresetn) begin
            acc_r     <= {(MAG_W+4){1'b0}};
            cnt_r     <= 4'h0;
            out_valid <= 1'b0;
            out_mag   <= {MAG_W{1'b0}};
        end else begin
            out_valid <= 1'b0;
            if (in_valid && !freeze) begin
                if (cnt_r == last_cnt) begin
                    out_valid <= 1'b1;
                    out_mag   <= avg_full[MAG_W-1:0];
                    acc_r     <= {(MAG_W+4){1'b0}};
                    cnt_r     <= 4'h0;
                end else begin
                    acc_r <= sum;
                    cnt_r <= cnt_r + 4'h1;
                end
            end
        end
    end
endmodule

// ---- core/csgh_top.v ----
// carrier sense qualifier and level-freeze control with an AXI4-Lite register slave
`timescale 1ns/1ps
`include "csgh_defs.vh"
module csgh_top #(
    parameter MAG_W = 8
) (
    // clock and reset
    input  wire             aclk,
    input  wire             aresetn,
    // axi4-lite write address
    input  wire             s_axi_awvalid,
    output reg              s_axi_awready,
    input  wire [7:0]       s_axi_awaddr,
    // axi4-lite write data
    input  wire             s_axi_wvalid,
    output reg              s_axi_wready,
    input  wire [31:0]      s_axi_wdata,
    input  wire [3:0]       s_axi_wstrb,
    // axi4-lite write response
    output reg              s_axi_bvalid,
    input  wire             s_axi_bready,
    output reg  [1:0]       s_axi_bresp,
    // axi4-lite read address
    input  wire             s_axi_arvalid,
    output reg              s_axi_arready,
    input  wire [7:0]       s_axi_araddr,
    // axi4-lite read data
    output reg              s_axi_rvalid,
    input  wire             s_axi_rready,
    output reg  [31:0]      s_axi_rdata,
    output reg  [1:0]       s_axi_rresp,
    // receiver datapath, same clock
    input  wire             filt_tick,
    input  wire             adc_tick,
    input  wire             mag_valid,
    input  wire [MAG_W-1:0] mag_in,
    input  wire [MAG_W-1:0] cs_threshold,
    input  wire             gain_change,
    input  wire             chan_switch,
    input  wire             rx_powerup,
    // synthesizer lock from the analog side
    input  wire             synth_lock_pin,
    input  wire             status_sel_cs,
    // outputs
    output reg              status_pin,
    output reg              carrier_sense,
    output reg              levels_frozen,
    output reg              second_amp_floor,
    output reg              avg_valid,
    output reg  [MAG_W-1:0] avg_mag
);
    localparam SEL_HOLD  = 0;
    localparam SEL_GAIN  = 1;
    localparam SEL_STAT  = 2;
    localparam SEL_EVENT = 3;

    // configuration and event registers
    reg  [7:0]       carrier_sense_hold_cfg_r;
    reg  [7:0]       amp_gain_limit_cfg_r;
    reg  [3:0]       sw_event_r;

    // write path holding registers
    reg  [7:0]       aw_addr_r;
    reg  [31:0]      w_data_r;
    reg  [3:0]       w_strb_r;
    reg              aw_have_r;
    reg              w_have_r;

    // carrier sense run counters
    reg  [2:0]       hi_run_r;
    reg  [1:0]       lo_run_r;

    // lock pin synchroniser and edge detector
    reg              lock_s1_r;
    reg              lock_s2_r;
    reg              lock_d_r;

    // read mux
    reg  [31:0]      rd_nxt;
    reg              rd_ok;

    // links between sub-blocks
    wire             avg_v;
    wire [MAG_W-1:0] avg_m;
    wire             frozen_w;
    wire             at_level;
    wire             lock_loss;
    wire [3:0]       hw_event;
    wire [3:0]       any_event;
    wire             retune;
    wire             gain_ev;
    wire [2:0]       hi_need;
    wire             wr_go;
    wire [3:0]       aw_hit;
    wire [3:0]       ar_hit;

    // one decoder for both bus directions keeps the map in a single place
    function [3:0] reg_hit;
        input [7:0] a;
        begin
            reg_hit            = 4'h0;
            reg_hit[SEL_HOLD]  = (a == `CSGH_ADDR_HOLD_CFG);
            reg_hit[SEL_GAIN]  = (a == `CSGH_ADDR_GAIN_CFG);
            reg_hit[SEL_STAT]  = (a == `CSGH_ADDR_STATUS);
            reg_hit[SEL_EVENT] = (a == `CSGH_ADDR_EVENT);
        end
    endfunction

    assign aw_hit = reg_hit(aw_addr_r);
    assign ar_hit = reg_hit(s_axi_araddr);

    // lock pin is asynchronous to aclk
    always @(posedge aclk) begin
        if (!aresetn) begin
            lock_s1_r <= 1'b0;
            lock_s2_r <= 1'b0;
            lock_d_r  <= 1'b0;
        end else begin
            lock_s1_r <= synth_lock_pin;
            lock_s2_r <= lock_s1_r;
            lock_d_r  <= lock_s2_r;
        end
    end

    // only a falling step of the synced pin counts as lock loss
    assign lock_loss = lock_d_r && !lock_s2_r;
    assign hw_event  = {rx_powerup, lock_loss, chan_switch, gain_change};

    // each event may come from its input or from a software pulse
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_event
            assign any_event[g] = hw_event[g] || sw_event_r[g];
        end
    endgenerate

    assign retune  = any_event[`CSGH_EV_CHAN] || any_event[`CSGH_EV_LOCK]
                     || any_event[`CSGH_EV_PWRUP];
    assign gain_ev = any_event[`CSGH_EV_GAIN];

    csgh_mag_avg #(
        .MAG_W (MAG_W)
    ) u_avg (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .avg_sel   (amp_gain_limit_cfg_r[`CSGH_AVG_HI:`CSGH_AVG_LO]),
        .freeze    (frozen_w),
        .in_valid  (mag_valid),
        .in_mag    (mag_in),
        .out_valid (avg_v),
        .out_mag   (avg_m)
    );

    csgh_freeze_timer u_frz (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .filt_tick    (filt_tick),
        .adc_tick     (adc_tick),
        .wait_sel     (carrier_sense_hold_cfg_r[`CSGH_WAIT_HI:`CSGH_WAIT_LO]),
        .frz_sel      (carrier_sense_hold_cfg_r[`CSGH_FRZ_HI:`CSGH_FRZ_LO]),
        .gain_change  (gain_ev),
        .retune_event (retune),
        .frozen       (frozen_w)
    );

    // carrier sense qualification on averaged samples
    assign hi_need  = {1'b0, carrier_sense_hold_cfg_r[`CSGH_SET_HI:`CSGH_SET_LO]} + 3'h1;
    assign at_level = (avg_m >= cs_threshold);

    always @(posedge aclk) begin
        if (!aresetn) begin
            hi_run_r      <= 3'h0;
            lo_run_r      <= 2'h0;
            carrier_sense <= 1'b0;
        end else if (avg_v) begin
            if (at_level) begin
                lo_run_r <= 2'h0;
                if (hi_run_r != `CSGH_SET_RUN_MAX)
                    hi_run_r <= hi_run_r + 3'h1;
                if (hi_run_r + 3'h1 >= hi_need)
                    carrier_sense <= 1'b1;
            end else begin
                hi_run_r <= 3'h0;
                if (lo_run_r != `CSGH_CLR_RUN_MAX)
                    lo_run_r <= lo_run_r + 2'h1;
                // two-sample clear is the advised setting against noise dropouts
                if (!carrier_sense_hold_cfg_r[`CSGH_CLR_BIT] || lo_run_r != 2'h0)
                    carrier_sense <= 1'b0;
            end
        end
    end

    // registered outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            status_pin       <= 1'b0;
            levels_frozen    <= 1'b0;
            second_amp_floor <= 1'b0;
            avg_valid        <= 1'b0;
            avg_mag          <= {MAG_W{1'b0}};
        end else begin
            // shared pin: carrier sense or synthesizer lock
            status_pin       <= status_sel_cs ? carrier_sense : lock_s2_r;
            levels_frozen    <= frozen_w;
            second_amp_floor <= amp_gain_limit_cfg_r[`CSGH_FLOOR_BIT];
            avg_valid        <= avg_v;
            avg_mag          <= avg_m;
        end
    end

    // axi4-lite write side: address and data taken in either order
    assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready            <= 1'b1;
            s_axi_wready             <= 1'b1;
            s_axi_bvalid             <= 1'b0;
            s_axi_bresp              <= `CSGH_RESP_OKAY;
            aw_have_r                <= 1'b0;
            w_have_r                 <= 1'b0;
            aw_addr_r                <= 8'h00;
            w_data_r                 <= 32'h0000_0000;
            w_strb_r                 <= 4'h0;
            carrier_sense_hold_cfg_r <= `CSGH_HOLD_RST;
            amp_gain_limit_cfg_r     <= `CSGH_GAIN_RST;
            sw_event_r               <= 4'h0;
        end else begin
            sw_event_r <= 4'h0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r     <= s_axi_awaddr;
                aw_have_r     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r     <= s_axi_wdata;
                w_strb_r     <= s_axi_wstrb;
                w_have_r     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (|aw_hit) ? `CSGH_RESP_OKAY : `CSGH_RESP_SLVERR;
                if (w_strb_r[0]) begin
                    if (aw_hit[SEL_HOLD])
                        carrier_sense_hold_cfg_r <= w_data_r[7:0];
                    if (aw_hit[SEL_GAIN])
                        amp_gain_limit_cfg_r <= w_data_r[7:0];
                    if (aw_hit[SEL_EVENT])
                        sw_event_r <= w_data_r[3:0];
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read mux
    always @* begin
        rd_nxt = 32'h0000_0000;
        rd_ok  = |ar_hit;
        // event register is write-only and reads as zero
        if (ar_hit[SEL_HOLD])
            rd_nxt = {24'h000000, carrier_sense_hold_cfg_r};
        if (ar_hit[SEL_GAIN])
            rd_nxt = {24'h000000, amp_gain_limit_cfg_r};
        if (ar_hit[SEL_STAT])
            rd_nxt = {29'h0, lock_s2_r, frozen_w, carrier_sense};
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `CSGH_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_nxt;
                s_axi_rresp   <= rd_ok ? `CSGH_RESP_OKAY : `CSGH_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule
